// file: hdl/port_pin_read_and_drain_control.sv
// Port block: pin-state readback, drain select, address and data port modes
//
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RQ1: The pin-state register is eight bits wide, read only, and ignores writes.
// RQ2: Software writes six-pin port output values only to the output latch register.
// RQ3: Bits 7 and 6 of pin-state and drain-select are reserved, read as zero and ignore writes.
// RQ4: A pin-state bit whose direction bit is 1 reads back the output latch value.
// RQ5: A pin-state bit whose direction bit is 0 reads back the synchronised pin level.
// RQ6: Reset and hardware standby clear direction and latch, so pin-state shows the pins.
// RQ7: In software standby the pin-state register holds its prior value.
// RQ8: A drain-select bit of 1 makes the pin open drain, never driving high.
// RQ9: A drain-select bit of 0 makes the pin push-pull, driving both levels.
// RQ10: Reset and hardware standby clear the six drain-select bits to zero.
// RQ11: In software standby the drain-select register keeps its contents.
// RQ12: In mode 6 an address-port pin with direction 1 drives address, else is input.
// RQ13: In mode 7 an address-port pin is plain I/O steered by its direction bit.
// RQ14: In modes 4 to 6 the data-port pins are the external data bus whatever their direction.
// RQ15: In mode 7 a data-port pin is plain I/O steered by its direction bit.
// RQ16: Without on-chip ROM, modes 6 and 7 are unavailable and their pin functions do not apply.
module port_pin_read_and_drain_control
    import port_pkg::*;
#(
    parameter bit HAS_ROM = 1'b1
) (
    input  wire logic                       I_CLOCK,
    input  wire logic                       I_RESET,
    input  wire logic                       I_HW_STANDBY,
    input  wire logic                       I_SW_STANDBY,
    input  wire logic [2:0]                 I_MODE,
    input  wire logic                       HSEL,
    input  wire logic [31:0]                HADDR,
    input  wire logic [1:0]                 HTRANS,
    input  wire logic                       HWRITE,
    input  wire logic [2:0]                 HSIZE,
    input  wire logic [31:0]                HWDATA,
    input  wire logic                       HREADY,
    output logic      [31:0]                HRDATA,
    output logic                            HREADYOUT,
    output logic                            HRESP,
    input  wire logic [PORT_WIDTH-1:0]      I_PORT_PIN,
    output logic      [PORT_WIDTH-1:0]      O_PORT_PIN,
    output logic      [PORT_WIDTH-1:0]      O_PORT_PIN_OE,
    input  wire logic [ADDR_PORT_WIDTH-1:0] I_ADDR_PIN,
    output logic      [ADDR_PORT_WIDTH-1:0] O_ADDR_PIN,
    output logic      [ADDR_PORT_WIDTH-1:0] O_ADDR_PIN_OE,
    input  wire logic [ADDR_PORT_WIDTH-1:0] I_EXT_ADDR,
    input  wire logic [DATA_PORT_WIDTH-1:0] I_DATA_PIN,
    output logic      [DATA_PORT_WIDTH-1:0] O_DATA_PIN,
    output logic      [DATA_PORT_WIDTH-1:0] O_DATA_PIN_OE,
    input  wire logic [DATA_PORT_WIDTH-1:0] I_EXT_DATA_OUT,
    input  wire logic                       I_EXT_DATA_DRIVE,
    output logic      [DATA_PORT_WIDTH-1:0] O_EXT_DATA_IN
);

    // Pin synchronisers
    logic [PORT_WIDTH-1:0]      pin_meta;
    logic [PORT_WIDTH-1:0]      pin_sync;
    logic [ADDR_PORT_WIDTH-1:0] addr_meta;
    logic [ADDR_PORT_WIDTH-1:0] addr_sync;
    logic [DATA_PORT_WIDTH-1:0] data_meta;
    logic [DATA_PORT_WIDTH-1:0] data_sync;

    always_ff @(posedge I_CLOCK) begin
        pin_meta  <= I_PORT_PIN;
        pin_sync  <= pin_meta;
        addr_meta <= I_ADDR_PIN;
        addr_sync <= addr_meta;
        data_meta <= I_DATA_PIN;
        data_sync <= data_meta;
    end

    // Bus address phase capture
    bus_req_s req;
    logic     init;

    assign init = I_RESET | I_HW_STANDBY;

    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            req <= '0;
        end else if (HREADY) begin
            req.sel   <= HSEL & (HTRANS == HTRANS_NONSEQ);
            req.write <= HWRITE;
            req.addr  <= HADDR[ADDR_WIDTH-1:0];
        end
    end

    function automatic logic wr_hit(input bus_req_s r, input logic [7:0] off);
        return r.sel & r.write & (r.addr == off);
    endfunction

    // Registers
    logic [PORT_WIDTH-1:0]      output_latch_reg;
    logic [PORT_WIDTH-1:0]      direction_reg;
    logic [PORT_WIDTH-1:0]      drain_select_reg;
    logic [PORT_WIDTH-1:0]      pin_state_reg;
    logic [ADDR_PORT_WIDTH-1:0] address_port_direction;
    logic [DATA_PORT_WIDTH-1:0] data_port_direction;
    logic [ADDR_PORT_WIDTH-1:0] addr_port_latch;
    logic [DATA_PORT_WIDTH-1:0] data_port_latch;
    logic                       sw_write_ok;

    assign sw_write_ok = ~I_SW_STANDBY;

    always_ff @(posedge I_CLOCK) begin
        if (init) begin
            output_latch_reg <= LATCH_RESET; // RQ6
            direction_reg    <= LATCH_RESET; // RQ6
        end else if (sw_write_ok) begin
            if (wr_hit(req, OFF_OUTPUT_LATCH))
                output_latch_reg <= HWDATA[PORT_WIDTH-1:0]; // RQ2
            if (wr_hit(req, OFF_DIRECTION))
                direction_reg <= HWDATA[PORT_WIDTH-1:0];
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (init) begin
            drain_select_reg <= DRAIN_SELECT_RESET; // RQ10
        end else if (sw_write_ok && wr_hit(req, OFF_DRAIN_SELECT)) begin
            drain_select_reg <= HWDATA[PORT_WIDTH-1:0]; // RQ3 RQ11
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (init) begin
            address_port_direction <= '0;
            data_port_direction    <= '0;
            addr_port_latch        <= '0;
            data_port_latch        <= '0;
        end else if (sw_write_ok) begin
            if (wr_hit(req, OFF_ADDR_PORT_DIR))
                address_port_direction <= HWDATA[ADDR_PORT_WIDTH-1:0];
            if (wr_hit(req, OFF_DATA_PORT_DIR))
                data_port_direction <= HWDATA[DATA_PORT_WIDTH-1:0];
            if (wr_hit(req, OFF_ADDR_PORT_OUT))
                addr_port_latch <= HWDATA[ADDR_PORT_WIDTH-1:0];
            if (wr_hit(req, OFF_DATA_PORT_OUT))
                data_port_latch <= HWDATA[DATA_PORT_WIDTH-1:0];
        end
    end

    // Pin-state: latch for outputs, pin for inputs; frozen in software standby
    always_ff @(posedge I_CLOCK) begin
        if (!I_SW_STANDBY) begin // RQ7
            pin_state_reg <= (direction_reg & output_latch_reg)
                           | (~direction_reg & pin_sync); // RQ4 RQ5
        end
    end

    // Read data: no write path into pin-state exists
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = '0;
        unique case (HADDR[ADDR_WIDTH-1:0])
            OFF_PIN_STATE:     next_rdata = {24'h0000_00, RESERVED_READ, pin_state_reg}; // RQ1 RQ3
            OFF_DRAIN_SELECT:  next_rdata = {24'h0000_00, RESERVED_READ, drain_select_reg}; // RQ3
            OFF_OUTPUT_LATCH:  next_rdata = {24'h0000_00, RESERVED_READ, output_latch_reg};
            OFF_DIRECTION:     next_rdata = {24'h0000_00, RESERVED_READ, direction_reg};
            OFF_ADDR_PORT_DIR: next_rdata = {24'h0000_00, address_port_direction};
            OFF_DATA_PORT_DIR: next_rdata = {24'h0000_00, data_port_direction};
            OFF_ADDR_PORT_OUT: next_rdata = {24'h0000_00, addr_sync};
            OFF_DATA_PORT_OUT: next_rdata = {24'h0000_00, data_sync};
            default:           next_rdata = '0;
        endcase
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            HRDATA    <= '0;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else if (HREADY && HSEL && HTRANS == HTRANS_NONSEQ && !HWRITE) begin
            HRDATA <= next_rdata;
        end
    end

    // Six-pin port drive: open drain never drives high
    pin_drive_s p3;
    always_ff @(posedge I_CLOCK) begin
        if (init) begin
            p3 <= '0;
        end else begin
            p3.out <= output_latch_reg & ~drain_select_reg; // RQ9
            p3.oe  <= direction_reg & (~drain_select_reg | ~output_latch_reg); // RQ8 RQ9
        end
    end
    assign O_PORT_PIN    = p3.out;
    assign O_PORT_PIN_OE = p3.oe;

    // Address and data ports by operating mode
    logic rom_mode6;
    logic rom_mode7;
    logic bus_mode;

    assign rom_mode6 = HAS_ROM && I_MODE == MODE_EXP_ROM; // RQ16
    assign rom_mode7 = HAS_ROM && I_MODE == MODE_SINGLE; // RQ16
    assign bus_mode  = I_MODE == MODE_EXP_4 || I_MODE == MODE_EXP_5 || rom_mode6; // RQ14 RQ16

    always_ff @(posedge I_CLOCK) begin
        if (init) begin
            O_ADDR_PIN    <= '0;
            O_ADDR_PIN_OE <= '0;
        end else if (rom_mode6) begin
            O_ADDR_PIN    <= I_EXT_ADDR; // RQ12
            O_ADDR_PIN_OE <= address_port_direction; // RQ12
        end else if (rom_mode7) begin
            O_ADDR_PIN    <= addr_port_latch; // RQ13
            O_ADDR_PIN_OE <= address_port_direction; // RQ13
        end else begin
            O_ADDR_PIN    <= I_EXT_ADDR;
            O_ADDR_PIN_OE <= '1;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (init) begin
            O_DATA_PIN    <= '0;
            O_DATA_PIN_OE <= '0;
            O_EXT_DATA_IN <= '0;
        end else begin
            O_EXT_DATA_IN <= data_sync;
            if (bus_mode) begin
                O_DATA_PIN    <= I_EXT_DATA_OUT; // RQ14
                O_DATA_PIN_OE <= {DATA_PORT_WIDTH{I_EXT_DATA_DRIVE}}; // RQ14
            end else if (rom_mode7) begin
                O_DATA_PIN    <= data_port_latch; // RQ15
                O_DATA_PIN_OE <= data_port_direction; // RQ15
            end else begin
                O_DATA_PIN    <= '0;
                O_DATA_PIN_OE <= '0;
            end
        end
    end

    // Checks
    AST_SELECT_HOLD: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RQ11
        I_SW_STANDBY && !I_HW_STANDBY |=> $stable(drain_select_reg))
        else $error("Drain select changed in software standby");
    AST_SELECT_INIT: assert property (@(posedge I_CLOCK) I_HW_STANDBY |=> drain_select_reg == '0) // RQ10
        else $error("Drain select not cleared");
    AST_STATE_HOLD: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RQ7
        I_SW_STANDBY |=> $stable(pin_state_reg))
        else $error("Pin state changed in software standby");
    AST_READ_LATCH: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RQ4
        !I_SW_STANDBY |=> ((pin_state_reg & $past(direction_reg)) == ($past(output_latch_reg) & $past(direction_reg))))
        else $error("Output bit does not read latch");
    AST_READ_PIN: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RQ5
        !I_SW_STANDBY |=> ((pin_state_reg & ~$past(direction_reg)) == ($past(pin_sync) & ~$past(direction_reg))))
        else $error("Input bit does not read pin");
    AST_OPEN_DRAIN: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RQ8
        (O_PORT_PIN & O_PORT_PIN_OE & $past(drain_select_reg)) == '0)
        else $error("Open drain pin driven high");
    AST_INIT_DIR: assert property (@(posedge I_CLOCK) init |=> direction_reg == '0 && output_latch_reg == '0) // RQ6
        else $error("Direction or latch not initialised");
    AST_MODE6_ADDR: assert property (@(posedge I_CLOCK) disable iff (init) // RQ12
        rom_mode6 |=> O_ADDR_PIN_OE == $past(address_port_direction))
        else $error("Mode 6 address enable wrong");
    AST_MODE7_DATA: assert property (@(posedge I_CLOCK) disable iff (init) // RQ15
        rom_mode7 |=> O_DATA_PIN == $past(data_port_latch) && O_DATA_PIN_OE == $past(data_port_direction))
        else $error("Mode 7 data port wrong");
    AST_BUS_DATA: assert property (@(posedge I_CLOCK) disable iff (init) // RQ14
        bus_mode |=> O_DATA_PIN_OE == {DATA_PORT_WIDTH{$past(I_EXT_DATA_DRIVE)}})
        else $error("Data bus enable wrong");

    // Bus-side sequences: drain write takes its address phase, then its data phase closes; pin-state read is address phase only
    sequence drain_write_taken;
        HREADY && HSEL && HTRANS == HTRANS_NONSEQ && HWRITE && HADDR[ADDR_WIDTH-1:0] == OFF_DRAIN_SELECT
            ##1 HREADY && !init && !I_SW_STANDBY;
    endsequence

    sequence pin_state_read;
        HREADY && HSEL && HTRANS == HTRANS_NONSEQ && !HWRITE && HADDR[ADDR_WIDTH-1:0] == OFF_PIN_STATE;
    endsequence

    // Push-pull bits follow direction and latch
    sequence push_pull_drive;
        ((O_PORT_PIN_OE & ~$past(drain_select_reg)) == ($past(direction_reg) & ~$past(drain_select_reg)))
            && ((O_PORT_PIN & ~$past(drain_select_reg)) == ($past(output_latch_reg) & ~$past(drain_select_reg)));
    endsequence

    AST_DRAIN_WRITE: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RQ3
        drain_write_taken |=> drain_select_reg == $past(HWDATA[PORT_WIDTH-1:0]))
        else $error("Drain select write lost");
    AST_STATE_READ: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RQ1
        pin_state_read |=> HRDATA == {24'h0000_00, RESERVED_READ, $past(pin_state_reg)})
        else $error("Pin state read data wrong");
    AST_PUSH_PULL: assert property (@(posedge I_CLOCK) disable iff (I_RESET) // RQ9
        !init |=> push_pull_drive)
        else $error("Push-pull pin not driven from latch");
    AST_MODE6_OUT: assert property (@(posedge I_CLOCK) disable iff (init) // RQ12
        rom_mode6 |=> O_ADDR_PIN == $past(I_EXT_ADDR))
        else $error("Mode 6 address value wrong");
    AST_MODE7_ADDR: assert property (@(posedge I_CLOCK) disable iff (init) // RQ13
        rom_mode7 |=> O_ADDR_PIN == $past(addr_port_latch) && O_ADDR_PIN_OE == $past(address_port_direction))
        else $error("Mode 7 address port wrong");
    AST_BUS_OUT: assert property (@(posedge I_CLOCK) disable iff (init) // RQ14
        bus_mode |=> O_DATA_PIN == $past(I_EXT_DATA_OUT))
        else $error("Data bus value wrong");
    AST_NO_ROM: assert property (@(posedge I_CLOCK) disable iff (init) // RQ16
        !HAS_ROM && (I_MODE == MODE_EXP_ROM || I_MODE == MODE_SINGLE)
            |=> O_DATA_PIN_OE == '0 && O_ADDR_PIN_OE == '1)
        else $error("Mode without on-chip ROM not refused");

endmodule : port_pin_read_and_drain_control
`default_nettype wire

// file: hdl/port_pkg.sv
// Package: register map, field layouts and mode codes for the port block
package port_pkg;
    localparam int          PORT_WIDTH         = 6;
    localparam int          ADDR_WIDTH         = 8;
    localparam int          WORD_WIDTH         = 32;
    localparam int          DATA_PORT_WIDTH    = 8;
    localparam int          ADDR_PORT_WIDTH    = 8;
    localparam logic [7:0]  OFF_PIN_STATE      = 8'h00;
    localparam logic [7:0]  OFF_DRAIN_SELECT   = 8'h04;
    localparam logic [7:0]  OFF_OUTPUT_LATCH   = 8'h08;
    localparam logic [7:0]  OFF_DIRECTION      = 8'h0C;
    localparam logic [7:0]  OFF_ADDR_PORT_DIR  = 8'h10;
    localparam logic [7:0]  OFF_DATA_PORT_DIR  = 8'h14;
    localparam logic [7:0]  OFF_ADDR_PORT_OUT  = 8'h18;
    localparam logic [7:0]  OFF_DATA_PORT_OUT  = 8'h1C;
    localparam logic [5:0]  DRAIN_SELECT_RESET = 6'h00;
    localparam logic [5:0]  LATCH_RESET        = 6'h00;
    localparam logic [1:0]  RESERVED_READ      = 2'h0;
    localparam logic [2:0]  MODE_EXP_4         = 3'h4;
    localparam logic [2:0]  MODE_EXP_5         = 3'h5;
    localparam logic [2:0]  MODE_EXP_ROM       = 3'h6;
    localparam logic [2:0]  MODE_SINGLE        = 3'h7;
    localparam logic [1:0]  HTRANS_NONSEQ      = 2'b10;

    typedef struct packed {
        logic                  sel;
        logic                  write;
        logic [ADDR_WIDTH-1:0] addr;
    } bus_req_s;

    typedef struct packed {
        logic [PORT_WIDTH-1:0] out;
        logic [PORT_WIDTH-1:0] oe;
    } pin_drive_s;
endpackage : port_pkg

// file: testbench/pin_board_model.sv
// Board model: resolves each pin from the device drive and the board level
`timescale 1ns/1ps
`default_nettype none
module pin_board_model #(
    parameter int W = 6
) (
    input  wire logic [W-1:0] i_out,
    input  wire logic [W-1:0] i_oe,
    input  wire logic [W-1:0] i_board,
    output logic      [W-1:0] o_level
);
    // Released bits follow the board, so an open-drain high shows the board level
    assign o_level = (i_out & i_oe) | (i_board & ~i_oe);
endmodule : pin_board_model
`default_nettype wire

// file: testbench/port_pin_read_and_drain_control_test.sv
// Testbench: bus, pin and mode checks of the port block
`timescale 1ns/1ps
`default_nettype none
module port_pin_read_and_drain_control_test;
    import port_pkg::*;
    logic        i_clock, i_reset, hw_sb, sw_sb, hsel, hwrite, ext_drive, hreadyout, hresp;
    logic [2:0]  mode, hsize;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [5:0]  p_out, p_oe, p_brd, p_lvl;
    logic [7:0]  a_out, a_oe, a_brd, a_lvl, d_out, d_oe, d_brd, d_lvl, ext_addr, ext_data, ext_in;
    logic [7:0]  nr_a_oe, nr_d_oe;
    int          n_fail, comparisons, cycles;

    port_pin_read_and_drain_control port_pin_read_and_drain_control_inst (
        .I_CLOCK(i_clock), .I_RESET(i_reset), .I_HW_STANDBY(hw_sb), .I_SW_STANDBY(sw_sb), .I_MODE(mode),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .I_PORT_PIN(p_lvl), .O_PORT_PIN(p_out), .O_PORT_PIN_OE(p_oe),
        .I_ADDR_PIN(a_lvl), .O_ADDR_PIN(a_out), .O_ADDR_PIN_OE(a_oe), .I_EXT_ADDR(ext_addr),
        .I_DATA_PIN(d_lvl), .O_DATA_PIN(d_out), .O_DATA_PIN_OE(d_oe), .I_EXT_DATA_OUT(ext_data),
        .I_EXT_DATA_DRIVE(ext_drive), .O_EXT_DATA_IN(ext_in));
    // Variant without on-chip ROM, fed the same stimulus
    port_pin_read_and_drain_control #(.HAS_ROM(1'b0)) norom_port_pin_read_and_drain_control_inst (
        .I_CLOCK(i_clock), .I_RESET(i_reset), .I_HW_STANDBY(hw_sb), .I_SW_STANDBY(sw_sb), .I_MODE(mode),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(), .HREADYOUT(), .HRESP(),
        .I_PORT_PIN(p_lvl), .O_PORT_PIN(), .O_PORT_PIN_OE(),
        .I_ADDR_PIN(a_lvl), .O_ADDR_PIN(), .O_ADDR_PIN_OE(nr_a_oe), .I_EXT_ADDR(ext_addr),
        .I_DATA_PIN(d_lvl), .O_DATA_PIN(), .O_DATA_PIN_OE(nr_d_oe), .I_EXT_DATA_OUT(ext_data),
        .I_EXT_DATA_DRIVE(ext_drive), .O_EXT_DATA_IN());
    pin_board_model #(.W(6)) pin_board_model_inst (.i_out(p_out), .i_oe(p_oe), .i_board(p_brd), .o_level(p_lvl));
    pin_board_model #(.W(8)) addr_board_inst (.i_out(a_out), .i_oe(a_oe), .i_board(a_brd), .o_level(a_lvl));
    pin_board_model #(.W(8)) data_board_inst (.i_out(d_out), .i_oe(d_oe), .i_board(d_brd), .o_level(d_lvl));

    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail = n_fail + 1;
            final_report();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One single transfer; read data taken at the end of the data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0000_00, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge i_clock); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge i_clock); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("response", 32'h0000_0000, {31'h0, hresp});
    endtask : bus

    task automatic settle;
        repeat (4) @(posedge i_clock);
    endtask : settle

    task automatic t_reset_and_reserved;
        bus(1'b0, OFF_DRAIN_SELECT, 0);
        chk("drain after reset", 32'h0000_0000, rd);
        bus(1'b0, OFF_PIN_STATE, 0);
        chk("pins after reset", 32'h0000_002A, rd);
        bus(1'b1, OFF_PIN_STATE, 32'h0000_00FF);
        bus(1'b0, OFF_PIN_STATE, 0);
        chk("pin state write", 32'h0000_002A, rd);
        bus(1'b1, OFF_DRAIN_SELECT, 32'h0000_00FF);
        bus(1'b0, OFF_DRAIN_SELECT, 0);
        chk("drain reserved", 32'h0000_003F, rd);
        bus(1'b1, OFF_DRAIN_SELECT, 0);
        $display("reset and reserved done");
    endtask : t_reset_and_reserved

    task automatic t_readback;
        bus(1'b1, OFF_OUTPUT_LATCH, 32'h0000_0015);
        bus(1'b1, OFF_DIRECTION, 32'h0000_000F);
        settle();
        bus(1'b0, OFF_PIN_STATE, 0);
        chk("mixed readback", 32'h0000_0025, rd);
        $display("readback done");
    endtask : t_readback

    task automatic t_drain;
        bus(1'b1, OFF_OUTPUT_LATCH, 32'h0000_0003);
        bus(1'b1, OFF_DIRECTION, 32'h0000_0003);
        bus(1'b1, OFF_DRAIN_SELECT, 32'h0000_0001);
        settle();
        chk("drive enable", 32'h0000_0002, {26'h0, p_oe});
        chk("drive value", 32'h0000_0002, {26'h0, p_out & p_oe});
        $display("drain done");
    endtask : t_drain

    task automatic t_standby;
        bus(1'b0, OFF_PIN_STATE, 0);
        chk("pins before standby", 32'h0000_002B, rd);
        sw_sb <= 1'b1;
        bus(1'b1, OFF_DRAIN_SELECT, 32'h0000_003E);
        p_brd <= 6'h15;
        settle();
        bus(1'b0, OFF_PIN_STATE, 0);
        chk("frozen pins", 32'h0000_002B, rd);
        bus(1'b0, OFF_DRAIN_SELECT, 0);
        chk("held drain", 32'h0000_0001, rd);
        sw_sb <= 1'b0;
        hw_sb <= 1'b1;
        settle();
        hw_sb <= 1'b0;
        settle();
        bus(1'b0, OFF_DRAIN_SELECT, 0);
        chk("drain hw standby", 32'h0000_0000, rd);
        bus(1'b0, OFF_PIN_STATE, 0);
        chk("pins hw standby", 32'h0000_0015, rd);
        $display("standby done");
    endtask : t_standby

    task automatic t_modes;
        ext_addr <= 8'hA5;
        ext_data <= 8'h5A;
        ext_drive <= 1'b1;
        bus(1'b1, OFF_ADDR_PORT_DIR, 32'h0000_00F0);
        bus(1'b1, OFF_ADDR_PORT_OUT, 32'h0000_003C);
        bus(1'b1, OFF_DATA_PORT_DIR, 32'h0000_000F);
        bus(1'b1, OFF_DATA_PORT_OUT, 32'h0000_0066);
        mode <= MODE_EXP_ROM;
        settle();
        chk("addr oe mode 6", 32'h0000_00F0, {24'h0, a_oe});
        chk("addr out mode 6", 32'h0000_00A0, {24'h0, a_out & a_oe});
        chk("data oe mode 6", 32'h0000_00FF, {24'h0, d_oe});
        chk("data out mode 6", 32'h0000_005A, {24'h0, d_out});
        chk("no rom addr oe mode 6", 32'h0000_00FF, {24'h0, nr_a_oe});
        chk("no rom data oe mode 6", 32'h0000_0000, {24'h0, nr_d_oe});
        mode <= MODE_EXP_4;
        settle();
        chk("data oe mode 4", 32'h0000_00FF, {24'h0, d_oe});
        mode <= MODE_SINGLE;
        settle();
        chk("addr oe mode 7", 32'h0000_00F0, {24'h0, a_oe});
        chk("addr out mode 7", 32'h0000_0030, {24'h0, a_out & a_oe});
        chk("data oe mode 7", 32'h0000_000F, {24'h0, d_oe});
        chk("data out mode 7", 32'h0000_0006, {24'h0, d_out & d_oe});
        chk("no rom addr oe mode 7", 32'h0000_00FF, {24'h0, nr_a_oe});
        chk("no rom data oe mode 7", 32'h0000_0000, {24'h0, nr_d_oe});
        bus(1'b0, OFF_ADDR_PORT_OUT, 0);
        chk("addr pins mode 7", 32'h0000_003F, rd);
        bus(1'b0, OFF_DATA_PORT_OUT, 0);
        chk("data pins mode 7", 32'h0000_00C6, rd);
        chk("data in mode 7", 32'h0000_00C6, {24'h0, ext_in});
        $display("modes done");
    endtask : t_modes

    initial begin
        n_fail = 0;
        comparisons = 0;
        cycles = 0;
        i_reset = 1'b1;
        {hw_sb, sw_sb, hsel, hwrite, ext_drive} = 5'h00;
        mode = MODE_EXP_5;
        hsize = 3'h2;
        htrans = 2'b00;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        {p_brd, a_brd, d_brd} = {6'h2A, 8'h0F, 8'hC3};
        {ext_addr, ext_data} = 16'h0000;
        repeat (12) @(posedge i_clock);
        i_reset <= 1'b0;
        t_reset_and_reserved();
        t_readback();
        t_drain();
        t_standby();
        t_modes();
        final_report();
    end
endmodule : port_pin_read_and_drain_control_test
`default_nettype wire
